// [inc/ccsr_pkg.sv]
// Package of constants and carrier types for the common command and status block.
// Functional notes
// - Clear-status zeroes events, status byte, error queue.
// - Status byte bit 5 is enabled-event OR.
// - Event register layout: PON, CME, EXE, DDE, QYE, OPC.
// - Any reset sets the power-on event bit.
// - Command and execution errors set their bits.
// - Device and query errors set their bits.
// - Complete command sets bit once operations idle.
// - Complete query answers ASCII one when idle; the core answers only if nothing is pending when the query is taken.
// - Service enable written 0-255, bit 6 ignored.
// - Status bit 6 is OR of enabled bits.
// - Serial poll clears service request; summary unaffected.
// - Status byte layout: operation_summary, MSS, ESB, MAV, quest, errq.
// - Status byte query reads without clearing anything.
// - Serial poll shows request bit, then clears it.
// - Trigger acts only while waiting flag armed.
// - Trigger loads levels and clears waiting flag outside continuous mode.
// - Continuous mode rearms and sets waiting flag.
// - Reset command restores zero outputs, plus-ten-percent limits.
// - Self-test query answers zero pass, one fail.
// - Wait command holds commands until operations idle.
// - Identification answers maker, model, serial, revision.
`default_nettype none
package ccsr_pkg;
    // Event status register bit positions.
    localparam int EV_PON = 7;
    localparam int EV_CME = 5;
    localparam int EV_EXE = 4;
    localparam int EV_DDE = 3;
    localparam int EV_QYE = 2;
    localparam int EV_OPC = 0;
    // Mask of the event bits that exist; bits 6 and 1 are unused.
    localparam logic [7:0] EV_USED = 8'hBD;
    // Status byte bit positions.
    localparam int SB_OPERATION_SUMMARY = 7;
    localparam int SB_MSS = 6;
    localparam int SB_ESB = 5;
    localparam int SB_MAV = 4;
    localparam int SB_QUESTIONABLE_SUMMARY = 3;
    localparam int SB_ERRQ = 2;
    // Reset values.
    localparam logic [7:0] EV_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] LEVEL_RESET = 16'h0000;
    // Response characters.
    localparam logic [7:0] ASCII_ONE = 8'h31;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_COMMA = 8'h2C;
    localparam logic [7:0] ASCII_DOT = 8'h2E;
    // Error queue depth counter width.
    localparam int ERRQ_W = 4;
    // Decoded common commands.
    typedef enum logic [3:0] {
        CCSR_NOP, CCSR_CLS, CCSR_ESE, CCSR_ESE_Q, CCSR_ESR_Q, CCSR_IDN_Q,
        CCSR_OPC, CCSR_OPC_Q, CCSR_RST, CCSR_SRE, CCSR_SRE_Q, CCSR_STB_Q,
        CCSR_TRG, CCSR_TST_Q, CCSR_WAI
    } ccsr_cmd_t;
    // Command request from the parser.
    typedef struct packed {
        logic      valid;
        ccsr_cmd_t cmd;
        logic [7:0] arg;
    } ccsr_req_t;
    // Error events reported by the parser and the instrument.
    typedef struct packed {
        logic cmd_err;
        logic exe_err;
        logic dev_err;
        logic qry_err;
    } ccsr_err_t;
    // Output setpoints.
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] pow;
        logic [15:0] overvoltage_limit;
        logic [15:0] overcurrent_limit;
    } ccsr_levels_t;
endpackage
`default_nettype wire

// [src/ccsr_core.sv]
// Common command interpreter with status byte and event reporting for a supply.
`timescale 1ns/1ps
`default_nettype none
module ccsr_core #(
    parameter logic [15:0] RATED_V = 16'h1000,  // Rated voltage code.
    parameter logic [15:0] RATED_I = 16'h1000,  // Rated current code.
    parameter logic [7:0]  MAKER_ID = 8'h41,    // Arbitrary maker character.
    parameter logic [7:0]  MODEL_ID = 8'h4D,    // Arbitrary model character.
    parameter logic [7:0]  SERIAL_CH = 8'h30,   // Arbitrary serial digit, sent six times.
    parameter logic [7:0]  FW_MAJOR = 8'h31,    // Arbitrary firmware major digit.
    parameter logic [7:0]  FW_MINOR = 8'h30     // Arbitrary firmware minor digit.
) (
    input  wire logic                   clk_i,       // 40 MHz clock.
    input  wire logic                   rst_i,       // Synchronous reset.
    input  wire ccsr_pkg::ccsr_req_t    req_i,       // Decoded command.
    output logic                        busy_o,      // Command not taken while high.
    input  wire ccsr_pkg::ccsr_err_t    err_i,       // Error events, one-cycle pulses.
    input  wire logic                   pending_i,   // Overlapped operations busy.
    input  wire logic                   selftest_fail_i, // Self-test result.
    input  wire logic                   operation_summary_sum_i,  // Operation summary level.
    input  wire logic                   questionable_summary_sum_i,  // Questionable summary level.
    input  wire logic                   mav_i,       // Output message available.
    input  wire logic                   errq_push_i, // Error entered into queue.
    input  wire logic                   errq_pop_i,  // Error read from queue.
    input  wire logic                   init_tran_i, // Transient mode initiated.
    input  wire logic                   cont_tran_i, // Continuous transient mode.
    input  wire logic                   abort_tran_i,// Transient disarm.
    input  wire logic [15:0]            trig_volt_i, // Preprogrammed voltage.
    input  wire logic [15:0]            trig_curr_i, // Preprogrammed current.
    input  wire logic [15:0]            trig_pow_i,  // Preprogrammed power.
    input  wire logic                   spoll_i,     // Serial poll request.
    output logic [7:0]                  spoll_o,     // Serial poll byte.
    output logic [7:0]                  resp_o,      // Response character.
    output logic                        resp_valid_o,// Response strobe.
    output logic                        resp_last_o, // Last character of answer.
    output logic                        trig_o,      // Trigger pulse.
    output logic                        waiting_for_trigger_flag_o, // Armed flag.
    output logic                        clear_events_o, // Clear other event registers.
    output ccsr_pkg::ccsr_levels_t      levels_o,    // Output setpoints.
    output logic [7:0]                  status_byte_o // Live status byte.
);
    import ccsr_pkg::*;

    logic [7:0]        standard_event_status;       // Sticky events.
    logic [7:0]        standard_event_enable_mask;  // Event mask.
    logic [7:0]        service_request_enable_mask; // Service mask.
    logic [ERRQ_W-1:0] errq_count;                  // Error queue fill.
    logic              rqs;                         // Request for service latch.
    logic              opc_armed;                   // Complete command waiting.
    logic              wai_hold;                    // Wait command holding.
    logic [7:0]        stb_base;                    // Status byte without bit 6.
    logic              mss;                         // Master summary.
    logic              mss_q;                       // Summary one cycle ago.
    logic [3:0]        idx;                         // Identity string index.
    logic              idn_run;                     // Identity string in progress.
    logic              take;                        // Command accepted.
    logic [7:0]        next_event;                  // Next event register.

    // A command is taken only when not stalled by a wait, a complete query or an identity answer.
    assign take = req_i.valid && !busy_o;

    // Status byte assembly; bit 6 is filled separately.
    always_comb
    begin
        stb_base = 8'h00;
        stb_base[SB_OPERATION_SUMMARY] = operation_summary_sum_i;
        stb_base[SB_ESB] = |(standard_event_status & standard_event_enable_mask);
        stb_base[SB_MAV] = mav_i;
        stb_base[SB_QUESTIONABLE_SUMMARY] = questionable_summary_sum_i;
        stb_base[SB_ERRQ] = (errq_count != '0);
        mss = |(stb_base & service_request_enable_mask);
    end

    // Event register: hardware sets win over any clear in the same cycle.
    always_comb
    begin
        next_event = standard_event_status;
        if (take && (req_i.cmd == CCSR_CLS || req_i.cmd == CCSR_ESR_Q))
        begin
            next_event = 8'h00;
        end
        if (err_i.cmd_err) next_event[EV_CME] = 1'b1;
        if (err_i.exe_err) next_event[EV_EXE] = 1'b1;
        if (err_i.dev_err || (take && req_i.cmd == CCSR_TST_Q && selftest_fail_i))
            next_event[EV_DDE] = 1'b1;
        if (err_i.qry_err) next_event[EV_QYE] = 1'b1;
        if (opc_armed && !pending_i) next_event[EV_OPC] = 1'b1;
        if (take && req_i.cmd == CCSR_RST) next_event[EV_PON] = 1'b1;
        next_event = next_event & EV_USED;
    end

    // Event register storage; reset reports a power-on event.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            standard_event_status <= EV_RESET;
        else
            standard_event_status <= next_event;
    end

    // Enable masks survive the clear-status command.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            standard_event_enable_mask <= MASK_RESET;
            service_request_enable_mask <= MASK_RESET;
        end
        else if (take && req_i.cmd == CCSR_ESE)
            standard_event_enable_mask <= req_i.arg & EV_USED;
        else if (take && req_i.cmd == CCSR_SRE)
        begin
            // Bit 6 is the summary itself, so it is never programmable.
            service_request_enable_mask <= req_i.arg & 8'hBF;
        end
    end

    // Error queue fill count; a push outranks the clear-status flush unless the count is full.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            errq_count <= '0;
        else if (errq_push_i && errq_count != '1)
            errq_count <= (take && req_i.cmd == CCSR_CLS) ? ERRQ_W'(1) : errq_count + 1'b1;
        else if (take && req_i.cmd == CCSR_CLS)
            errq_count <= '0;
        else if (errq_pop_i && errq_count != '0)
            errq_count <= errq_count - 1'b1;
    end

    // Summary history, so a standing summary does not re-request after a poll.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mss_q <= 1'b0;
        else
            mss_q <= mss;
    end

    // Request for service rises with a new summary and falls on a poll or a clear-status command.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rqs <= 1'b0;
        else if (mss && !mss_q)
            rqs <= 1'b1;
        else if (spoll_i)
            rqs <= 1'b0;
        else if (take && req_i.cmd == CCSR_CLS)
            rqs <= 1'b0;
    end

    // Poll byte carries the service request in bit 6 instead of the summary.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            spoll_o <= 8'h00;
        else if (spoll_i)
            spoll_o <= stb_base | {1'b0, rqs, 6'h00};
    end

    // Live status byte; reading it clears nothing.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_byte_o <= 8'h00;
        else
            status_byte_o <= stb_base | {1'b0, mss, 6'h00};
    end

    // Complete command waits for overlapped work to drain.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            opc_armed <= 1'b0;
        else if (take && req_i.cmd == CCSR_OPC)
            opc_armed <= 1'b1;
        else if (!pending_i)
            opc_armed <= 1'b0;
    end

    // Wait command and complete query both hold the command port until operations idle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wai_hold <= 1'b0;
        else if (take && (req_i.cmd == CCSR_WAI || req_i.cmd == CCSR_OPC_Q))
            wai_hold <= 1'b1;
        else if (!pending_i)
            wai_hold <= 1'b0;
    end

    // Busy output, registered one cycle after the cause.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            busy_o <= 1'b0;
        else
            busy_o <= (take && (req_i.cmd == CCSR_WAI || req_i.cmd == CCSR_OPC_Q ||
                        req_i.cmd == CCSR_IDN_Q)) ||
                      (wai_hold && pending_i) || (idn_run && idx != 4'd12);
    end

    // Identity string character select.
    function automatic logic [7:0] idn_char(input logic [3:0] i);
        case (i)
            4'd0: idn_char = MAKER_ID;
            4'd1, 4'd3, 4'd10: idn_char = ASCII_COMMA;
            4'd2: idn_char = MODEL_ID;
            4'd11: idn_char = FW_MAJOR;
            4'd12: idn_char = ASCII_DOT;
            4'd13: idn_char = FW_MINOR;
            default: idn_char = SERIAL_CH;
        endcase
    endfunction

    // Identity string walker, one character per clock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            idn_run <= 1'b0;
            idx <= 4'd0;
        end
        else if (take && req_i.cmd == CCSR_IDN_Q)
        begin
            idn_run <= 1'b1;
            idx <= 4'd0;
        end
        else if (idn_run)
        begin
            idx <= idx + 4'd1;
            if (idx == 4'd13)
                idn_run <= 1'b0;
        end
    end

    // Query answers; a complete query answers only if nothing is pending when it is taken.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            resp_o <= 8'h00;
            resp_valid_o <= 1'b0;
            resp_last_o <= 1'b0;
        end
        else
        begin
            resp_valid_o <= 1'b0;
            resp_last_o <= 1'b0;
            if (idn_run)
            begin
                resp_o <= idn_char(idx);
                resp_valid_o <= 1'b1;
                resp_last_o <= (idx == 4'd13);
            end
            else if (take)
            begin
                resp_valid_o <= 1'b1;
                resp_last_o <= 1'b1;
                case (req_i.cmd)
                    CCSR_ESE_Q: resp_o <= standard_event_enable_mask;
                    CCSR_ESR_Q: resp_o <= standard_event_status;
                    CCSR_SRE_Q: resp_o <= service_request_enable_mask;
                    CCSR_STB_Q: resp_o <= stb_base | {1'b0, mss, 6'h00};
                    CCSR_TST_Q: resp_o <= selftest_fail_i ? ASCII_ONE : ASCII_ZERO;
                    CCSR_OPC_Q:
                    begin
                        resp_valid_o <= !pending_i;
                        resp_o <= ASCII_ONE;
                    end
                    default:
                    begin
                        resp_valid_o <= 1'b0;
                        resp_last_o <= 1'b0;
                    end
                endcase
            end
            else if (wai_hold && !pending_i && !busy_o)
            begin
                resp_valid_o <= 1'b0;
            end
        end
    end

    // Clear pulse for operation and questionable event registers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clear_events_o <= 1'b0;
        else
            clear_events_o <= take && req_i.cmd == CCSR_CLS;
    end

    // Trigger arming and firing.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            waiting_for_trigger_flag_o <= 1'b0;
            trig_o <= 1'b0;
        end
        else
        begin
            trig_o <= take && req_i.cmd == CCSR_TRG && waiting_for_trigger_flag_o;
            if (take && req_i.cmd == CCSR_TRG && waiting_for_trigger_flag_o)
                waiting_for_trigger_flag_o <= cont_tran_i;
            else if (init_tran_i || cont_tran_i)
                waiting_for_trigger_flag_o <= 1'b1;
            else if (abort_tran_i || (take && req_i.cmd == CCSR_RST))
                waiting_for_trigger_flag_o <= 1'b0;
        end
    end

    // Output setpoints; reset and the reset command restore defaults.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (take && req_i.cmd == CCSR_RST))
        begin
            levels_o.volt <= LEVEL_RESET;
            levels_o.curr <= LEVEL_RESET;
            levels_o.pow <= LEVEL_RESET;
            // Limits sit ten percent above rating; the divide is exact enough.
            levels_o.overvoltage_limit <= RATED_V + RATED_V / 16'd10;
            levels_o.overcurrent_limit <= RATED_I + RATED_I / 16'd10;
        end
        else if (take && req_i.cmd == CCSR_TRG && waiting_for_trigger_flag_o)
        begin
            levels_o.volt <= trig_volt_i;
            levels_o.curr <= trig_curr_i;
            levels_o.pow <= trig_pow_i;
        end
    end
endmodule // ccsr_core
`default_nettype wire

// [tb/ccsr_core_monitor.sv]
// Concurrent checks on the command, trigger and answer ports of the core.
`timescale 1ns/1ps
`default_nettype none
module ccsr_core_monitor #(
    parameter logic [15:0] RATED_V = 16'h1000, // Rated voltage code.
    parameter logic [15:0] RATED_I = 16'h1000  // Rated current code.
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire ccsr_pkg::ccsr_req_t    req_i,
    input wire logic                   busy_o,
    input wire logic                   pending_i,
    input wire logic                   selftest_fail_i,
    input wire logic                   cont_tran_i,
    input wire logic [15:0]            trig_volt_i,
    input wire logic [7:0]             resp_o,
    input wire logic                   resp_valid_o,
    input wire logic                   resp_last_o,
    input wire logic                   trig_o,
    input wire logic                   waiting_for_trigger_flag_o,
    input wire logic                   clear_events_o,
    input wire ccsr_pkg::ccsr_levels_t levels_o,
    input wire logic [7:0]             status_byte_o
);
    import ccsr_pkg::*;
    // Everything lives in one clock domain, so clock and reset are set once.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A command counts as taken only on an edge where the port is not stalled.
    sequence s_take(ccsr_cmd_t c);
        req_i.valid && !busy_o && req_i.cmd == c;
    endsequence
    chk_cls_pulse_out: assert property (s_take(CCSR_CLS) |=> clear_events_o)
        else $error("clear pulse missing after clear command");
    chk_trig_armed_only: assert property (trig_o |-> $past(waiting_for_trigger_flag_o))
        else $error("trigger pulse while not armed");
    chk_trig_level_load: assert property (trig_o |-> levels_o.volt == $past(trig_volt_i))
        else $error("trigger did not load voltage level");
    chk_trig_rearm_flag: assert property (trig_o |-> waiting_for_trigger_flag_o == $past(cont_tran_i))
        else $error("armed flag wrong after trigger");
    chk_opc_query_one: assert property (s_take(CCSR_OPC_Q) ##0 !pending_i |=>
        resp_valid_o && resp_o == ASCII_ONE)
        else $error("complete query answer wrong");
    chk_tst_query_ans: assert property (s_take(CCSR_TST_Q) |=> resp_valid_o &&
        resp_o == ($past(selftest_fail_i) ? ASCII_ONE : ASCII_ZERO))
        else $error("self test answer wrong");
    chk_wai_holds_port: assert property (s_take(CCSR_WAI) ##0 pending_i |=> busy_o [*3])
        else $error("wait command did not stall the port");
    chk_rst_cmd_levels: assert property (s_take(CCSR_RST) |=> levels_o.volt == 16'h0000 &&
        levels_o.curr == 16'h0000 && levels_o.overvoltage_limit == RATED_V + RATED_V / 10 &&
        levels_o.overcurrent_limit == RATED_I + RATED_I / 10)
        else $error("reset command levels wrong");
    chk_last_has_valid: assert property (resp_last_o |-> resp_valid_o)
        else $error("last flag without a character");
    chk_stb_unused_low: assert property (status_byte_o[1:0] == 2'b00)
        else $error("unused status bits set");
endmodule // ccsr_core_monitor
bind ccsr_core ccsr_core_monitor #(.RATED_V(RATED_V), .RATED_I(RATED_I)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .busy_o(busy_o), .pending_i(pending_i),
    .selftest_fail_i(selftest_fail_i), .cont_tran_i(cont_tran_i), .trig_volt_i(trig_volt_i),
    .resp_o(resp_o), .resp_valid_o(resp_valid_o), .resp_last_o(resp_last_o), .trig_o(trig_o),
    .waiting_for_trigger_flag_o(waiting_for_trigger_flag_o), .clear_events_o(clear_events_o),
    .levels_o(levels_o), .status_byte_o(status_byte_o));
`default_nettype wire

// [tb/ccsr_host.sv]
// Host controller model that hands decoded common commands to the core.
`timescale 1ns/1ps
`default_nettype none
module ccsr_host (
    input  wire logic              clk_i,  // Core clock.
    input  wire logic              busy_i, // Core stall flag.
    output var ccsr_pkg::ccsr_req_t req_o  // Request toward the core.
);
    import ccsr_pkg::*;
    initial req_o = '0;
    // Holds the request until an edge with the port free or 400 stalled cycles pass, then drops it.
    // The argument is eight bits wide, so it always lies in 0 to 255.
    task automatic send(input ccsr_cmd_t c, input logic [7:0] a);
        int n;
        n = 0;
        @(negedge clk_i);
        req_o <= {1'b1, c, a};
        #1;
        while (busy_i === 1'b1 && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        req_o <= '0;
    endtask
endmodule // ccsr_host
`default_nettype wire

// [tb/test_common_command_status_reporting.sv]
// Self-checking bench for the common command and status core.
`timescale 1ns/1ps
`default_nettype none
module test_common_command_status_reporting;
    import ccsr_pkg::*;
    localparam logic [15:0] RV = 16'h1000; // Rated voltage code.
    localparam logic [15:0] RI = 16'h0800; // Rated current code.
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    ccsr_req_t    req;
    ccsr_err_t    err_i = '0;
    logic         pending_i = 1'b0, fail_i = 1'b0, operation_summary_i = 1'b0, questionable_summary_i = 1'b0, mav_i = 1'b0;
    logic         push_i = 1'b0, init_i = 1'b0, cont_i = 1'b0, spoll_i = 1'b0;
    logic [15:0]  tv = 16'h0123, tc = 16'h0456, tp = 16'h0789; // Preset trigger levels.
    logic         busy_o, resp_valid_o, resp_last_o, trig_o, wtf_o, clr_o;
    logic [7:0]   spoll_o, resp_o, status_byte_o;
    ccsr_levels_t levels_o;
    logic [7:0]   rq[$];          // Answer characters seen so far.
    int           n_last = 0, n_trig = 0, n_clr = 0, mismatches = 0, n_tests = 0;
    // The clock runs at 40 MHz.
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    ccsr_host host (.clk_i(clk_i), .busy_i(busy_o), .req_o(req));
    ccsr_core #(.RATED_V(RV), .RATED_I(RI)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .busy_o(busy_o), .err_i(err_i),
        .pending_i(pending_i), .selftest_fail_i(fail_i), .operation_summary_sum_i(operation_summary_i),
        .questionable_summary_sum_i(questionable_summary_i), .mav_i(mav_i), .errq_push_i(push_i), .errq_pop_i(1'b0),
        .init_tran_i(init_i), .cont_tran_i(cont_i), .abort_tran_i(1'b0), .trig_volt_i(tv),
        .trig_curr_i(tc), .trig_pow_i(tp), .spoll_i(spoll_i), .spoll_o(spoll_o),
        .resp_o(resp_o), .resp_valid_o(resp_valid_o), .resp_last_o(resp_last_o),
        .trig_o(trig_o), .waiting_for_trigger_flag_o(wtf_o), .clear_events_o(clr_o),
        .levels_o(levels_o), .status_byte_o(status_byte_o));
    // Pulse outputs stand one cycle, so they are collected at every edge.
    always @(posedge clk_i)
    begin
        if (resp_valid_o === 1'b1) rq.push_back(resp_o);
        if (resp_last_o === 1'b1) n_last++;
        if (trig_o === 1'b1) n_trig++;
        if (clr_o === 1'b1) n_clr++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Sends a query and compares its single answer character; none counts as wrong.
    task automatic ask(input ccsr_cmd_t c, input logic [7:0] a, input logic [7:0] e);
        int n;
        rq.delete();
        host.send(c, a);
        for (n = 0; n < 20 && rq.size() == 0; n++) @(negedge clk_i);
        chk({8'h00, (rq.size() > 0) ? rq.pop_front() : 8'hxx}, {8'h00, e});
    endtask
    task automatic pulse_err(input ccsr_err_t e);
        @(negedge clk_i) err_i = e;
        @(negedge clk_i) err_i = '0;
    endtask
    task automatic poll(input logic [7:0] e);
        @(negedge clk_i) spoll_i = 1'b1;
        @(negedge clk_i) spoll_i = 1'b0;
        chk({8'h00, spoll_o}, {8'h00, e});
    endtask
    // Reset defaults, then reset command first as a careful host does.
    task automatic t_reset();
        chk(levels_o.overvoltage_limit, RV + RV / 10);
        chk(levels_o.overcurrent_limit, RI + RI / 10);
        host.send(CCSR_RST, 8'h00);
        ask(CCSR_ESR_Q, 8'h00, 8'h80);
        ask(CCSR_ESR_Q, 8'h00, 8'h00);
    endtask
    // Error events with the mask off and on.
    task automatic t_events();
        pulse_err(4'b1000);
        idle(2);
        chk(status_byte_o[5], 1'b0);
        ask(CCSR_ESR_Q, 8'h00, 8'h20);
        host.send(CCSR_ESE, 8'h3C);
        pulse_err(4'b1111);
        idle(2);
        chk(status_byte_o[5], 1'b1);
        ask(CCSR_ESR_Q, 8'h00, 8'h3C);
        idle(2);
        chk(status_byte_o[5], 1'b0);
        ask(CCSR_ESE_Q, 8'h00, 8'h3C);
    endtask
    // Status byte, summary, polls and clear-status.
    task automatic t_status();
        host.send(CCSR_SRE, 8'hFF);
        ask(CCSR_SRE_Q, 8'h00, 8'hBF);
        host.send(CCSR_ESE, 8'h04);
        pulse_err(4'b0001);
        {operation_summary_i, questionable_summary_i, mav_i, push_i} = 4'b1111;
        @(negedge clk_i) push_i = 1'b0;
        idle(3);
        chk(status_byte_o, 8'hFC);
        ask(CCSR_STB_Q, 8'h00, 8'hFC);
        ask(CCSR_STB_Q, 8'h00, 8'hFC);
        poll(8'hFC);
        poll(8'hBC);
        chk(status_byte_o[6], 1'b1);
        {operation_summary_i, questionable_summary_i, mav_i} = 3'b000;
        idle(3);
        chk(status_byte_o, 8'h64);
        host.send(CCSR_CLS, 8'h00);
        idle(3);
        chk(status_byte_o, 8'h00);
        chk(16'(n_clr), 16'h0001);
        ask(CCSR_ESE_Q, 8'h00, 8'h04);
        ask(CCSR_SRE_Q, 8'h00, 8'hBF);
    endtask
    // Completion with overlapped work, wait stall and self test.
    task automatic t_sync();
        pending_i = 1'b1;
        host.send(CCSR_OPC, 8'h00);
        idle(4);
        ask(CCSR_ESR_Q, 8'h00, 8'h00);
        pending_i = 1'b0;
        idle(4);
        ask(CCSR_ESR_Q, 8'h00, 8'h01);
        ask(CCSR_OPC_Q, 8'h00, ASCII_ONE);
        pending_i = 1'b1;
        host.send(CCSR_WAI, 8'h00);
        idle(6);
        chk(busy_o, 1'b1);
        pending_i = 1'b0;
        idle(4);
        chk(busy_o, 1'b0);
        ask(CCSR_TST_Q, 8'h00, ASCII_ZERO);
        fail_i = 1'b1;
        ask(CCSR_TST_Q, 8'h00, ASCII_ONE);
        fail_i = 1'b0;
        ask(CCSR_ESR_Q, 8'h00, 8'h08);
    endtask
    task automatic arm();
        @(negedge clk_i) init_i = 1'b1;
        @(negedge clk_i) init_i = 1'b0;
        idle(2);
    endtask
    // Trigger unarmed, armed once, continuous, then reset command.
    task automatic t_trig();
        host.send(CCSR_TRG, 8'h00);
        idle(2);
        chk(16'(n_trig), 16'h0000);
        chk(levels_o.volt, 16'h0000);
        arm();
        chk(wtf_o, 1'b1);
        host.send(CCSR_TRG, 8'h00);
        idle(2);
        chk(16'(n_trig), 16'h0001);
        chk(levels_o.volt, tv);
        chk(levels_o.curr, tc);
        chk(levels_o.pow, tp);
        chk(wtf_o, 1'b0);
        cont_i = 1'b1;
        arm();
        host.send(CCSR_TRG, 8'h00);
        host.send(CCSR_TRG, 8'h00);
        idle(2);
        chk(16'(n_trig), 16'h0003);
        chk(wtf_o, 1'b1);
        host.send(CCSR_RST, 8'h00);
        idle(2);
        chk(levels_o.volt, 16'h0000);
        chk(levels_o.curr, 16'h0000);
        chk(levels_o.overvoltage_limit, RV + RV / 10);
    endtask
    // Identification string, fourteen characters with the last one flagged.
    task automatic t_ident();
        logic [7:0] e[14];
        e = '{8'h41, 8'h2C, 8'h4D, 8'h2C, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30,
              8'h2C, 8'h31, 8'h2E, 8'h30};
        rq.delete();
        n_last = 0;
        host.send(CCSR_IDN_Q, 8'h00);
        idle(20);
        chk(16'(rq.size()), 16'd14);
        for (int i = 0; i < 14 && i < rq.size(); i++) chk({8'h00, rq[i]}, {8'h00, e[i]});
        chk(16'(n_last), 16'h0001);
    endtask
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog sized well beyond the couple of hundred cycles the tests need.
    initial
    begin
        #(25 * 20000);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        t_reset();
        t_events();
        t_status();
        t_sync();
        t_trig();
        t_ident();
        give_verdict();
    end
endmodule // test_common_command_status_reporting
`default_nettype wire
